// ==== modbus_host.sv ====
// Fieldbus master: builds command frames, parses drive responses
`include "modbus_host_regs.svh"

module modbus_host #(
	parameter int unsigned GAP_CYCLES  = `GAP_CYCLES,
	parameter int unsigned RESP_CYCLES = `RESP_CYCLES,
	parameter int unsigned MAX_WORDS   = `MAX_WORDS_DEF
) (
	// Clock and reset
	input  wire logic                     ref_clk_i,
	input  wire logic                     reset_i,
	// Command request
	input  wire logic                     cmd_valid_i,
	output logic                          cmd_ready_o,
	input  wire logic                     cmd_ascii_i,
	input  wire logic [7:0]               cmd_station_i,
	input  wire logic [7:0]               cmd_func_i,
	input  wire logic [15:0]              cmd_reg_i,
	input  wire logic [7:0]               cmd_count_i,
	// Write data words
	input  wire logic                     wr_valid_i,
	output logic                          wr_ready_o,
	input  wire logic [15:0]              wr_word_i,
	// Read data words and result
	output logic                          rd_valid_o,
	output logic      [15:0]              rd_word_o,
	output logic                          done_o,
	output modbus_host_pkg::status_t      status_o,
	// Serial byte link
	output logic                          tx_valid_o,
	input  wire logic                     tx_ready_i,
	output logic      [7:0]               tx_data_o,
	input  wire logic                     rx_valid_i,
	input  wire logic [7:0]               rx_data_i
);
	import modbus_host_pkg::*;

	// Parameter sanity
	if (GAP_CYCLES < 1 || RESP_CYCLES < 1 || MAX_WORDS < 1 || MAX_WORDS > 20)
		$error("modbus_host: unsupported parameter value");

	state_t      state;
	state_t      next_state;
	logic        ascii;
	logic [7:0]  station;
	logic [7:0]  func;
	logic [15:0] reg_addr;
	logic [7:0]  cnt;
	logic [15:0] word;
	logic        have_word;
	logic [6:0]  pos;
	logic        nib;
	logic        started;
	logic [1:0]  tail;
	logic [31:0] timer;
	logic [6:0]  ridx;
	logic        rnib;
	logic [3:0]  rhi;
	logic        cr_seen;
	logic        bad;
	logic        mism;
	logic [7:0]  rd_hi;
	logic        slot;
	logic        need_word;
	logic        tx_feed;
	logic        tx_finish;
	logic        rx_byte_v;
	logic        rx_end;
	logic        timeout;
	logic        clear;
	logic [7:0]  nbytes;
	logic [7:0]  total;
	logic [7:0]  exp_len;
	logic [7:0]  cur_byte;
	logic [7:0]  rx_byte;
	logic [7:0]  enc_asc;
	logic [3:0]  dec_nib;
	logic        dec_ok;
	logic [15:0] crc;
	logic [7:0]  sum;

	// Binary content of the command frame at byte position i
	function automatic logic [7:0] frame_byte(input logic [6:0] i);
		logic [7:0] b;
		case (i)
			7'h00:   b = station;
			7'h01:   b = func;
			7'h02:   b = reg_addr[15:8];
			7'h03:   b = reg_addr[7:0];
			7'h04:   b = (func == `FN_WRITE1) ? word[15:8] : 8'h00;
			7'h05:   b = (func == `FN_WRITE1) ? word[7:0] : cnt;
			7'h06:   b = {cnt[6:0], 1'b0};
			default: b = i[0] ? word[15:8] : word[7:0];
		endcase
		return b;
	endfunction : frame_byte

	// Shared hex codec and checksum unit
	hex_codec u_hex (
		.nib_i (nib ? cur_byte[3:0] : cur_byte[7:4]),
		.asc_o (enc_asc),
		.asc_i (rx_data_i),
		.nib_o (dec_nib),
		.ok_o  (dec_ok)
	);

	frame_check u_check (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.clear_i   (clear),
		.feed_i    (tx_feed || rx_byte_v),
		.byte_i    (tx_feed ? cur_byte : rx_byte),
		.crc_o     (crc),
		.sum_o     (sum)
	);

	// Frame lengths, current byte, link strobes
	always_comb
	begin
		nbytes = (func == `FN_WRITEN) ? ({1'b0, `POS_WRITEN_DAT} + {cnt[6:0], 1'b0}) : `LEN_SHORT;
		total = nbytes + (ascii ? `LEN_LRC : `LEN_CRC);
		exp_len = ((func == `FN_READ) ? (`LEN_READ_HDR + {cnt[6:0], 1'b0}) : `LEN_SHORT)
			+ (ascii ? `LEN_LRC : `LEN_CRC);
		if ({1'b0, pos} < nbytes)
			cur_byte = frame_byte(pos);
		else if (ascii)
			cur_byte = 8'h00 - sum;
		else if ({1'b0, pos} == nbytes)
			cur_byte = crc[7:0];
		else
			cur_byte = crc[15:8];
		slot = !tx_valid_o || tx_ready_i;
		need_word = !have_word && !nib && ((func == `FN_WRITE1 && pos == `POS_WRITE1_VAL)
			|| (func == `FN_WRITEN && pos >= `POS_WRITEN_DAT && pos[0]
			&& {1'b0, pos} < nbytes));
		tx_feed = state == S_TX && slot && started && !need_word
			&& {1'b0, pos} < nbytes && (!ascii || nib);
		tx_finish = state == S_TX && slot && {1'b0, pos} >= total
			&& (!ascii || tail == `TAIL_DONE);
		rx_byte = ascii ? {rhi, dec_nib} : rx_data_i;
		rx_byte_v = state == S_RX && rx_valid_i && (!ascii || (rnib && dec_ok));
		rx_end = state == S_RX && (ascii
			? (rx_valid_i && rx_data_i == `ASCII_LF && cr_seen)
			: (ridx != 7'h00 && !rx_valid_i && timer >= GAP_CYCLES - 1));
		timeout = state == S_RX && !rx_end && timer >= RESP_CYCLES - 1;
		clear = state == S_GAP || tx_finish
			|| (state == S_RX && ascii && rx_valid_i && rx_data_i == `ASCII_START);
	end

	// Sequencing of one transaction
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE:  if (cmd_valid_i) next_state = S_GAP;
			S_GAP:   if (ascii || timer >= GAP_CYCLES - 1) next_state = S_TX;
			S_TX:
			begin
				// Park only once the pending link byte is gone, or it would go out twice
				if (need_word && started && slot)
					next_state = S_WAITW;
				else if (tx_finish)
					next_state = (station == `STATION_BCAST) ? S_DONE : S_RX;
			end
			S_WAITW: if (wr_valid_i && wr_ready_o) next_state = S_TX;
			S_RX:    if (rx_end || timeout) next_state = S_DONE;
			S_DONE:  next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	// Silence and timeout timer, restarted by line activity
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
			timer <= 32'h0;
		else if (state != next_state || rx_valid_i)
			timer <= 32'h0;
		else if (timer != 32'hffffffff)
			timer <= timer + 32'h1;
	end

	// Command capture
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ascii <= 1'b0;
			station <= 8'h00;
			func <= 8'h00;
			reg_addr <= 16'h0;
			cnt <= 8'h00;
		end
		else if (state == S_IDLE && cmd_valid_i)
		begin
			ascii <= cmd_ascii_i;
			station <= cmd_station_i;
			func <= cmd_func_i;
			reg_addr <= cmd_reg_i;
			if (cmd_func_i == `FN_WRITEN && cmd_count_i > MAX_WORDS[7:0])
				cnt <= MAX_WORDS[7:0];
			else
				cnt <= cmd_count_i;
		end
	end

	// Transmit side: delimiters, hex or raw bytes, checksum
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h00;
			pos <= 7'h00;
			nib <= 1'b0;
			started <= 1'b0;
			tail <= 2'h0;
			have_word <= 1'b0;
			word <= 16'h0;
			wr_ready_o <= 1'b0;
		end
		else
		begin
			wr_ready_o <= next_state == S_WAITW;
			if (state == S_WAITW && wr_valid_i && wr_ready_o)
			begin
				word <= wr_word_i;
				have_word <= 1'b1;
			end
			if (state == S_GAP)
			begin
				pos <= 7'h00;
				nib <= 1'b0;
				tail <= 2'h0;
				started <= !ascii;
				have_word <= 1'b0;
			end
			else if (state == S_TX && slot)
			begin
				tx_valid_o <= 1'b0;
				if (!started)
				begin
					tx_valid_o <= 1'b1;
					tx_data_o <= `ASCII_START;
					started <= 1'b1;
				end
				else if (need_word)
					tx_valid_o <= 1'b0;
				else if ({1'b0, pos} < total)
				begin
					tx_valid_o <= 1'b1;
					if (ascii)
					begin
						tx_data_o <= enc_asc;
						nib <= !nib;
						if (nib)
							pos <= pos + 7'h1;
					end
					else
					begin
						tx_data_o <= cur_byte;
						pos <= pos + 7'h1;
					end
					if ((!ascii || nib) && !pos[0] && pos >= `POS_WRITE1_VAL)
						have_word <= 1'b0;
				end
				else if (ascii && tail != `TAIL_DONE)
				begin
					tx_valid_o <= 1'b1;
					tx_data_o <= (tail == 2'h0) ? `ASCII_CR : `ASCII_LF;
					tail <= tail + 2'h1;
				end
			end
		end
	end

	// Receive side: hex pairing, framing and content checks
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ridx <= 7'h00;
			rnib <= 1'b0;
			rhi <= 4'h0;
			cr_seen <= 1'b0;
			bad <= 1'b0;
			mism <= 1'b0;
			rd_hi <= 8'h00;
			rd_word_o <= 16'h0;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= 1'b0;
			if (state != S_RX || clear)
			begin
				ridx <= 7'h00;
				rnib <= 1'b0;
				cr_seen <= 1'b0;
				bad <= 1'b0;
				mism <= 1'b0;
			end
			else if (rx_valid_i && ascii)
			begin
				cr_seen <= rx_data_i == `ASCII_CR;
				if (rx_data_i == `ASCII_LF && !cr_seen)
					bad <= 1'b1;
				else if (rx_data_i != `ASCII_CR && rx_data_i != `ASCII_LF)
				begin
					if (!dec_ok || cr_seen)
						bad <= 1'b1;
					rnib <= dec_ok && !rnib;
					rhi <= dec_nib;
				end
			end
			if (rx_byte_v)
			begin
				if (ridx != 7'h7f)
					ridx <= ridx + 7'h1;
				if ((ridx == 7'h00 && rx_byte != station) || (ridx == 7'h01 && rx_byte != func))
					mism <= 1'b1;
				if (func == `FN_READ)
				begin
					if (ridx == `POS_ECHO_FIRST && rx_byte != {cnt[6:0], 1'b0})
						mism <= 1'b1;
					if (ridx > `POS_ECHO_FIRST && {1'b0, ridx} < exp_len - (ascii ? `LEN_LRC : `LEN_CRC))
					begin
						if (ridx[0])
							rd_hi <= rx_byte;
						else
						begin
							rd_word_o <= {rd_hi, rx_byte};
							rd_valid_o <= 1'b1;
						end
					end
				end
				else if (ridx >= `POS_ECHO_FIRST && ridx <= `POS_ECHO_LAST
					&& rx_byte != frame_byte(ridx))
					mism <= 1'b1;
			end
		end
	end

	// Result reporting and command handshake
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			done_o <= 1'b0;
			status_o <= ST_OK;
			cmd_ready_o <= 1'b0;
		end
		else
		begin
			cmd_ready_o <= next_state == S_IDLE;
			done_o <= next_state == S_DONE;
			if (state == S_TX && next_state == S_DONE)
				status_o <= ST_OK;
			else if (timeout)
				status_o <= ST_TIMEOUT;
			else if (rx_end)
			begin
				if (bad || {1'b0, ridx} != exp_len || (ascii ? sum != 8'h00 : crc != 16'h0))
					status_o <= ST_BAD_CHECK;
				else if (mism)
					status_o <= ST_MISMATCH;
				else
					status_o <= ST_OK;
			end
		end
	end

endmodule : modbus_host

// ==== modbus_host_regs.svh ====
// Framing constants and timing figures for the fieldbus host controller
`ifndef MODBUS_HOST_REGS_SVH
`define MODBUS_HOST_REGS_SVH

// Frame delimiter characters
`define ASCII_START   8'h3a
`define ASCII_CR      8'h0d
`define ASCII_LF      8'h0a

// Hex digit character bases
`define ASCII_ZERO    8'h30
`define ASCII_NINE    8'h39
`define ASCII_UP_A    8'h41
`define ASCII_UP_F    8'h46
`define HEX_TEN       8'h0a

// Station and function codes
`define STATION_BCAST 8'h00
`define FN_READ       8'h03
`define FN_WRITE1     8'h06
`define FN_WRITEN     8'h10

// Checksum constants
`define CRC_PRESET    16'hffff
`define CRC_POLY      16'ha001

// Frame layout: byte positions and lengths
`define POS_WRITE1_VAL 7'h04
`define POS_WRITEN_DAT 7'h07
`define POS_ECHO_FIRST 7'h02
`define POS_ECHO_LAST  7'h05
`define LEN_SHORT      8'h06
`define LEN_READ_HDR   8'h03
`define LEN_LRC        8'h01
`define LEN_CRC        8'h02
`define TAIL_DONE      2'h2

// Timing: clock rate, RTU silence gap and response timeout
`define CLK_HZ        125000000
`define GAP_US        10000
`define RESP_US       100000
`define GAP_CYCLES    ((`CLK_HZ / 1000000) * `GAP_US + 1)
`define RESP_CYCLES   ((`CLK_HZ / 1000000) * `RESP_US)
`define MAX_WORDS_DEF 20

`endif

// ==== modbus_host_pkg.sv ====
// Types shared by the fieldbus host controller modules
package modbus_host_pkg;

	// Controller states, Gray coded along idle-gap-send-receive-done
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_GAP   = 3'h1,
		S_TX    = 3'h3,
		S_RX    = 3'h2,
		S_DONE  = 3'h6,
		S_WAITW = 3'h7
	} state_t;

	// Outcome of one transaction
	typedef enum logic [1:0] {
		ST_OK        = 2'h0,
		ST_BAD_CHECK = 2'h1,
		ST_MISMATCH  = 2'h2,
		ST_TIMEOUT   = 2'h3
	} status_t;

endpackage : modbus_host_pkg

// ==== hex_codec.sv ====
// Nibble to hex character encoder and hex character decoder
`include "modbus_host_regs.svh"

module hex_codec (
	// Encoder
	input  wire logic [3:0] nib_i,
	output logic      [7:0] asc_o,
	// Decoder
	input  wire logic [7:0] asc_i,
	output logic      [3:0] nib_o,
	output logic            ok_o
);

	logic [7:0] wide;
	logic [7:0] diff;

	// Digits 0-9 and upper-case A-F both ways
	always_comb
	begin
		wide = {4'h0, nib_i};
		if (wide < `HEX_TEN)
			asc_o = `ASCII_ZERO + wide;
		else
			asc_o = `ASCII_UP_A + wide - `HEX_TEN;
		diff = 8'h00;
		ok_o = 1'b0;
		if (asc_i >= `ASCII_ZERO && asc_i <= `ASCII_NINE)
		begin
			diff = asc_i - `ASCII_ZERO;
			ok_o = 1'b1;
		end
		else if (asc_i >= `ASCII_UP_A && asc_i <= `ASCII_UP_F)
		begin
			diff = asc_i - `ASCII_UP_A + `HEX_TEN;
			ok_o = 1'b1;
		end
		nib_o = diff[3:0];
	end

endmodule : hex_codec

// ==== frame_check.sv ====
// Running CRC-16 and byte sum over frame bytes
`include "modbus_host_regs.svh"

module frame_check (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// Byte feed
	input  wire logic        clear_i,
	input  wire logic        feed_i,
	input  wire logic [7:0]  byte_i,
	// Results
	output logic      [15:0] crc_o,
	output logic      [7:0]  sum_o
);

	// One byte of the reflected CRC, eight shifts
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		return r;
	endfunction : crc_step

	// Accumulators, cleared before each frame
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			crc_o <= `CRC_PRESET;
			sum_o <= 8'h00;
		end
		else if (clear_i)
		begin
			crc_o <= `CRC_PRESET;
			sum_o <= 8'h00;
		end
		else if (feed_i)
		begin
			crc_o <= crc_step(crc_o, byte_i);
			sum_o <= sum_o + byte_i;
		end
	end

endmodule : frame_check

// ==== modbus_host_props.sv ====
// Port-level checks on the fieldbus host controller
module modbus_host_props #(
	parameter int unsigned GAP_CYCLES = 20
) (
	// Clock and reset
	input logic       ref_clk_i,
	input logic       reset_i,
	// Command and word handshakes
	input logic       cmd_valid_i,
	input logic       cmd_ready_o,
	input logic       cmd_ascii_i,
	input logic       wr_valid_i,
	input logic       wr_ready_o,
	input logic       done_o,
	// Link transmit side
	input logic       tx_valid_o,
	input logic       tx_ready_i,
	input logic [7:0] tx_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        first;
	logic        ascii;
	logic [7:0]  last;
	int unsigned quiet;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	// Command accepted, and its framing
	sequence take_s;
		cmd_valid_i && cmd_ready_o;
	endsequence
	sequence take_ascii_s;
		cmd_valid_i && cmd_ready_o && cmd_ascii_i;
	endsequence

	// Marks the first frame byte and counts the silence before it
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			first <= 1'b0;
			ascii <= 1'b0;
			quiet <= 0;
		end
		else if (cmd_valid_i && cmd_ready_o)
		begin
			first <= 1'b1;
			ascii <= cmd_ascii_i;
			quiet <= 0;
		end
		else if (tx_valid_o && tx_ready_i)
			first <= 1'b0;
		else
			quiet <= quiet + 1;
	end

	// Remembers the last byte the link accepted
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i || (cmd_valid_i && cmd_ready_o))
			last <= 8'h00;
		else if (tx_valid_o && tx_ready_i)
			last <= tx_data_o;
	end

	take_busy_a: assert property (take_s |=> !cmd_ready_o)
		else $error("command taken but ready stayed high");
	done_single_a: assert property (done_o |=> !done_o && cmd_ready_o)
		else $error("done not a single pulse followed by ready");
	done_busy_a: assert property (done_o |-> !cmd_ready_o)
		else $error("ready high together with done");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("link byte changed before acceptance");
	ascii_start_a: assert property (first && ascii && tx_valid_o |-> tx_data_o == 8'h3a)
		else $error("ascii frame does not open with colon");
	ascii_prompt_a: assert property (take_ascii_s |-> ##[1:4] tx_valid_o)
		else $error("ascii frame did not start promptly");
	rtu_silence_a: assert property (first && !ascii && tx_valid_o |-> quiet >= GAP_CYCLES - 1)
		else $error("rtu frame sent without leading silence");
	ascii_end_a: assert property (ascii && tx_valid_o && last == 8'h0d |-> tx_data_o == 8'h0a)
		else $error("carriage return not followed by line feed");
	ascii_chars_a: assert property (ascii && tx_valid_o && !first |->
		tx_data_o inside {[8'h30:8'h39], [8'h41:8'h46], 8'h0d, 8'h0a})
		else $error("ascii frame holds a non hex character");
	word_take_a: assert property (wr_valid_i && wr_ready_o |=> !wr_ready_o)
		else $error("write word taken but ready stayed high");
endmodule : modbus_host_props

bind modbus_host modbus_host_props #(.GAP_CYCLES(GAP_CYCLES)) props (.*);

// ==== modbus_dev_model.sv ====
// Behavioural drive on the far side of the serial byte link
module modbus_dev_model #(
	parameter int unsigned GAP     = 20,
	parameter logic [7:0]  STATION = 8'h01
) (
	// Clock, reset and bench controls
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	input  wire logic       slow_i,
	input  wire logic       corrupt_i,
	// Byte link
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	output logic            rx_valid_o,
	output logic      [7:0] rx_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:65535];
	logic [7:0]  q [$];
	logic [7:0]  b [$];
	int          idle;

	// Slow mode holds ready low every other cycle
	always @(posedge ref_clk_i or posedge reset_i)
		tx_ready_o <= !reset_i && (!slow_i || !tx_ready_o);

	function automatic logic [15:0] crc(input logic [7:0] d [$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (d[i])
		begin
			c = c ^ d[i];
			repeat (8)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction : crc

	function automatic logic [7:0] sum(input logic [7:0] d [$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (d[i])
			s = s + d[i];
		return s;
	endfunction : sum

	function automatic logic [7:0] enc(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
	endfunction : enc

	function automatic logic [3:0] dec(input logic [7:0] c);
		return c[3:0] + (c[6] ? 4'h9 : 4'h0);
	endfunction : dec

	task automatic put(input logic [7:0] x);
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b1;
		rx_data_o  <= x;
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o  <= ~x;
	endtask : put

	task automatic serve(input logic asc);
		logic [7:0]  r [$];
		logic [15:0] ck;
		logic [15:0] a;
		b = {};
		if (asc)
			for (int i = 1; i + 3 < q.size(); i += 2)
				b.push_back({dec(q[i]), dec(q[i + 1])});
		else
			b = q;
		if ((asc ? sum(b) != 8'h00 || q[q.size() - 2] != 8'h0d : crc(b) != 16'h0000)
			|| b.size() < 6)
			return;
		if (b[0] != STATION && b[0] != 8'h00)
			return;
		a = {b[2], b[3]};
		r = b[0:5];
		if (b[1] == 8'h03)
		begin
			r = {b[0], b[1], 8'(2 * b[5])};
			for (int k = 0; k < b[5]; k++)
				r = {r, mem[a + k][15:8], mem[a + k][7:0]};
		end
		else if (b[1] == 8'h06)
			mem[a] = {b[4], b[5]};
		else if (b[1] == 8'h10)
			for (int k = 0; k < b[5]; k++)
				mem[a + k] = {b[7 + 2 * k], b[8 + 2 * k]};
		else
			return;
		if (b[0] == 8'h00)
			return;
		ck = asc ? {8'h00, 8'h00 - sum(r)} : crc(r);
		ck[0] = ck[0] ^ corrupt_i;
		r.push_back(ck[7:0]);
		if (!asc)
			r.push_back(ck[15:8]);
		repeat (3) @(posedge ref_clk_i);
		if (asc)
			put(8'h3a);
		foreach (r[i])
		begin
			if (asc)
				put(enc(r[i][7:4]));
			put(asc ? enc(r[i][3:0]) : r[i]);
		end
		if (asc)
			put(8'h0d);
		if (asc)
			put(8'h0a);
	endtask : serve

	// Collects link bytes, closes frames on CR LF or on line silence
	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
		idle       = 0;
		forever
		begin
			@(posedge ref_clk_i);
			idle++;
			if (tx_valid_i && tx_ready_o)
			begin
				// A colon restarts only an ascii frame, never a raw byte inside an rtu frame
				if (tx_data_i == 8'h3a && (q.size() == 0 || q[0] == 8'h3a))
					q = {};
				q.push_back(tx_data_i);
				idle = 0;
			end
			if (q.size() > 0 && q[0] == 8'h3a && q[q.size() - 1] == 8'h0a)
			begin
				serve(1'b1);
				q = {};
			end
			else if (q.size() > 0 && q[0] != 8'h3a && idle > GAP)
				serve(1'b0);
			if (idle > GAP)
				q = {};
		end
	end
endmodule : modbus_dev_model

// ==== testbench.sv ====
// Self-checking bench for the fieldbus host controller
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import modbus_host_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cmd_valid_i = 1'b0;
	logic        cmd_ascii_i = 1'b0;
	logic [7:0]  cmd_station_i = 8'h00;
	logic [7:0]  cmd_func_i = 8'h00;
	logic [15:0] cmd_reg_i = 16'h0000;
	logic [7:0]  cmd_count_i = 8'h00;
	logic        wr_valid_i = 1'b0;
	logic [15:0] wr_word_i = 16'h0000;
	logic        slow = 1'b0;
	logic        corrupt = 1'b0;
	logic        cmd_ready_o, wr_ready_o, rd_valid_o, done_o, tx_valid_o, tx_ready_i, rx_valid_i;
	logic [15:0] rd_word_o;
	logic [7:0]  tx_data_o, rx_data_i;
	status_t     status_o, st;
	logic [15:0] wdata [0:19];
	logic [15:0] rq [$];
	int          errors = 0, num_checks = 0, cycles = 0, rx_seen = 0, n0;

	modbus_host #(.GAP_CYCLES(20), .RESP_CYCLES(200)) DUT (.*);
	modbus_dev_model #(.GAP(20)) partner (.ref_clk_i, .reset_i, .slow_i(slow),
		.corrupt_i(corrupt), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
		.tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));

	// Clock
	always #4 ref_clk_i = ~ref_clk_i;

	// Counts cycles and reply bytes, cuts a hang short
	always @(posedge ref_clk_i)
	begin
		cycles++;
		rx_seen += rx_valid_i;
		if (cycles == 20000)
		begin
			errors++;
			$display("mismatch run_time expected finish seen hang");
			final_report();
		end
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic run(input logic a, input logic [7:0] sn, fn, input logic [15:0] rg,
		input logic [7:0] n);
		int wi;
		wi = 0;
		rq = {};
		while (cmd_ready_o !== 1'b1)
			@(negedge ref_clk_i);
		{cmd_valid_i, cmd_ascii_i, cmd_station_i, cmd_func_i} = {1'b1, a, sn, fn};
		{cmd_reg_i, cmd_count_i} = {rg, n};
		do
		begin
			@(negedge ref_clk_i);
			cmd_valid_i = 1'b0;
			if (rd_valid_o === 1'b1)
				rq.push_back(rd_word_o);
			if (wr_valid_i)
			begin
				wr_valid_i = 1'b0;
				wi++;
			end
			else if (wr_ready_o === 1'b1)
			begin
				wr_word_i  = wdata[wi];
				wr_valid_i = 1'b1;
			end
		end
		while (done_o !== 1'b1);
		st = status_o;
	endtask : run

	task automatic t_single;
		for (int a = 0; a < 2; a++)
		begin
			wdata[0] = 16'h1770 + 16'(a);
			run(a[0], 8'h01, 8'h06, 16'h0100, 8'h01);
			check("write status", 16'(ST_OK), 16'(st));
			run(!a[0], 8'h01, 8'h03, 16'h0100, 8'h01);
			check("read count", 16'h0001, 16'(rq.size()));
			check("read word", wdata[0], rq[0]);
		end
		$display("test single write done");
	endtask : t_single

	task automatic t_multi;
		slow = 1'b1;
		for (int k = 0; k < 20; k++)
			wdata[k] = {8'(k), 8'h88 ^ 8'(3 * k)};
		run(1'b1, 8'h01, 8'h10, 16'h0500, 8'd20);
		check("multi status", 16'(ST_OK), 16'(st));
		slow = 1'b0;
		run(1'b0, 8'h01, 8'h03, 16'h0500, 8'd20);
		check("multi count", 16'd20, 16'(rq.size()));
		for (int k = 0; k < 20; k++)
			check("multi word", wdata[k], rq[k]);
		$display("test multi write done");
	endtask : t_multi

	task automatic t_bcast;
		wdata[0] = 16'hbeef;
		n0 = rx_seen;
		run(1'b0, 8'h00, 8'h06, 16'h0101, 8'h01);
		check("bcast status", 16'(ST_OK), 16'(st));
		// Trailing silence closes the frame at the drive and gives any reply time to show
		repeat (40) @(negedge ref_clk_i);
		check("bcast reply", 16'(n0), 16'(rx_seen));
		run(1'b1, 8'h01, 8'h03, 16'h0101, 8'h01);
		check("bcast word", 16'hbeef, rq[0]);
		$display("test broadcast done");
	endtask : t_bcast

	task automatic t_faults;
		run(1'b0, 8'h02, 8'h03, 16'h0100, 8'h01);
		check("foreign status", 16'(ST_TIMEOUT), 16'(st));
		corrupt = 1'b1;
		for (int a = 0; a < 2; a++)
		begin
			run(a[0], 8'h01, 8'h03, 16'h0100, 8'h01);
			check("bad check status", 16'(ST_BAD_CHECK), 16'(st));
		end
		corrupt = 1'b0;
		$display("test faults done");
	endtask : t_faults

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	// Main sequence
	initial
	begin
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		reset_i = 1'b0;
		t_single();
		t_multi();
		t_bcast();
		t_faults();
		final_report();
	end
endmodule : testbench
